// ==== pcpi_consts.vh ====
// constants for the pulse capture and pileup inspector: register offsets,
// field positions and reset values; assumes a 256-byte AHB-Lite window
`ifndef PCPI_CONSTS_VH
`define PCPI_CONSTS_VH

// register byte offsets
`define PCPI_CTRL       8'h00
`define PCPI_FAST_THR   8'h04
`define PCPI_INTER_THR  8'h08
`define PCPI_SLOW_LEN   8'h0c
`define PCPI_SLOW_GAP   8'h10
`define PCPI_SAMP_DLY   8'h14
`define PCPI_PILE_INT   8'h18
`define PCPI_MAX_WIDTH  8'h1c
`define PCPI_BASE_INT   8'h20
`define PCPI_STATUS     8'h24
`define PCPI_EV_STEP    8'h28
`define PCPI_EV_ADC     8'h2c
`define PCPI_BASE_STEP  8'h30
`define PCPI_BASE_ADC   8'h34
`define PCPI_REALTIME   8'h38
`define PCPI_LIVETIME   8'h3c
`define PCPI_PULSES     8'h40
`define PCPI_EVENTS     8'h44

// control fields
`define PCPI_CTRL_RUN    0
`define PCPI_CTRL_DEC_LO 1
`define PCPI_CTRL_DEC_HI 2
`define PCPI_CTRL_INTEN  3
`define PCPI_CTRL_FASTEN 4
`define PCPI_CTRL_RESET  5'h18

// status fields
`define PCPI_ST_READY   0
`define PCPI_ST_OVERRUN 1
`define PCPI_ST_BUSY    2

// decimation setting that selects fixed-delay sampling
`define PCPI_DEC_ZERO   2'h0

// ahb transfer type bit that marks an active transfer
`define PCPI_HTRANS_ACT 1

`endif

// ==== pcpi_timer.v ====
// decimated-cycle interval timer used for pileup inspection and baseline pacing
// assumes tick is a one-cycle strobe from logic on the same clock
`timescale 1ns/1ps

module pcpi_timer #(
  parameter CW = 16
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // control
  input  wire          start,
  input  wire          abort,
  input  wire          tick,
  input  wire [CW-1:0] limit,
  // state
  output reg           run_q,
  output reg  [CW-1:0] count_q,
  output reg           done_q
);

  wire [CW-1:0] count_inc = count_q + {{(CW-1){1'b0}}, 1'b1};

  // start restarts from zero; done pulses in the same cycle the count reaches limit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q   <= 1'b0;
      count_q <= {CW{1'b0}};
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        run_q   <= 1'b1;
        count_q <= {CW{1'b0}};
      end else if (abort) begin
        run_q <= 1'b0;
      end else if (run_q && tick) begin
        count_q <= count_inc;
        if (count_inc >= limit) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

endmodule

// ==== pcpi_top.v ====
// pulse capture and pileup inspector: detection, energy capture, pileup tests,
// baselines and run counters behind an AHB-Lite slave
// assumes filter and adc samples share clk and are valid when dec_tick pulses
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pcpi_consts.vh"

// Notes on behaviour
// - higher decimations keep window maximum as step
// - decimation zero samples slow output after delay
// - adc amplitude latched at each detection
// - baselines taken repeatedly while no trigger and no inspect interval active
// - second pulse within inspect interval flags pileup
// - slow pileup rejects both earlier and later pulse
// - fast pulse wider than maximum is rejected
// - merged fast pulses count as one detection
// - only events passing both tests are stored
// - run accumulates real, live, pulse, event counts
// - fast threshold crossing starts event processing
// - intermediate crossing also starts events when enabled, except at decimation zero
// - max window from length and inspect interval only
module pcpi_top #(
  parameter DW = 24,
  parameter AW = 12,
  parameter CW = 16
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // ahb-lite slave
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  // filter and adc samples
  input  wire          dec_tick,
  input  wire [DW-1:0] fast_filter,
  input  wire [DW-1:0] inter_filter,
  input  wire [DW-1:0] slow_filter,
  input  wire [AW-1:0] adc_sample,
  // accepted event toward spectrum memory
  output reg           spec_valid,
  output reg  [DW-1:0] spec_step,
  output reg  [AW-1:0] spec_adc
);

  // configuration registers
  reg  [4:0]    ctrl_q;
  reg  [DW-1:0] fast_thr_q;
  reg  [DW-1:0] inter_thr_q;
  reg  [CW-1:0] slow_filter_length_q;
  reg  [CW-1:0] slow_filter_gap_q;
  reg  [CW-1:0] peak_sample_delay_q;
  reg  [CW-1:0] pileup_inspect_interval_q;
  reg  [CW-1:0] max_fast_pulse_width_q;
  reg  [CW-1:0] base_interval_q;
  // captured results and status
  reg           ev_ready_q;
  reg           ev_overrun_q;
  reg  [DW-1:0] ev_step_q;
  reg  [AW-1:0] ev_adc_q;
  reg  [DW-1:0] base_step_q;
  reg  [AW-1:0] base_adc_q;
  reg  [31:0]   realtime_q;
  reg  [31:0]   livetime_q;
  reg  [31:0]   detected_pulse_count_q;
  reg  [31:0]   captured_event_count_q;
  // bus data phase
  reg           wr_pend_q;
  reg  [7:0]    wr_addr_q;
  reg  [31:0]   rd_mux;
  // detection and event state
  reg           fast_above_q;
  reg           trig_q;
  reg  [CW-1:0] width_q;
  reg           reject_q;
  reg  [DW-1:0] max_q;
  reg  [DW-1:0] samp_q;
  reg  [AW-1:0] adc_cap_q;
  reg           run_prev_q;

  wire          run      = ctrl_q[`PCPI_CTRL_RUN];
  wire [1:0]    dec_sel  = ctrl_q[`PCPI_CTRL_DEC_HI:`PCPI_CTRL_DEC_LO];
  wire          dec_zero = (dec_sel == `PCPI_DEC_ZERO);

  // address phase accepted
  wire addr_ok  = (haddr[31:8] == 24'h000000);
  wire acc      = hsel && hready && htrans[`PCPI_HTRANS_ACT];
  wire wr_strb  = wr_pend_q;

  // threshold comparisons on the current decimated sample
  wire fast_now  = ctrl_q[`PCPI_CTRL_FASTEN] && (fast_filter > fast_thr_q);
  wire inter_now = ctrl_q[`PCPI_CTRL_INTEN] && !dec_zero
                   && (inter_filter > inter_thr_q);
  wire trig_now  = fast_now || inter_now;
  // one detection per rise of the combined trigger level
  wire det       = run && dec_tick && trig_now && !trig_q;

  // pileup inspection timer
  wire          pile_run;
  wire [CW-1:0] pile_count;
  wire          pile_done;
  // baseline pacing timer
  wire          base_run;
  wire [CW-1:0] base_count;
  // quiet level is judged on ticks only; between ticks the samples are stale
  wire          idle = run && !trig_q && !pile_run && !(dec_tick && trig_now);

  pcpi_timer #(
    .CW(CW)
  ) u_pile_timer (
    .clk     (clk),
    .rst     (rst),
    .start   (det),
    .abort   (!run),
    .tick    (dec_tick),
    .limit   (pileup_inspect_interval_q),
    .run_q   (pile_run),
    .count_q (pile_count),
    .done_q  (pile_done)
  );

  pcpi_timer #(
    .CW(CW)
  ) u_base_timer (
    .clk     (clk),
    .rst     (rst),
    .start   (idle && !base_run),
    .abort   (!idle),
    .tick    (dec_tick),
    .limit   (base_interval_q),
    .run_q   (base_run),
    .count_q (base_count),
    .done_q  ()
  );

  // max window opens slow length before the inspect interval ends
  wire [CW-1:0] win_start = (pileup_inspect_interval_q > slow_filter_length_q) ?
                            (pileup_inspect_interval_q - slow_filter_length_q) :
                            {CW{1'b0}};
  wire in_win   = pile_run && dec_tick && (pile_count >= win_start);
  // sample point must come before the interval ends to be taken
  wire samp_hit = pile_run && dec_tick
                  && (pile_count + {{(CW-1){1'b0}}, 1'b1} == peak_sample_delay_q);
  // event finished with no second pulse in the same cycle
  wire ev_end   = pile_done && !det;
  wire ev_keep  = ev_end && !reject_q;
  wire [DW-1:0] step_val = dec_zero ? samp_q : max_q;

  // detection level history and fast pulse width
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_above_q <= 1'b0;
      trig_q       <= 1'b0;
      width_q      <= {CW{1'b0}};
    end else if (dec_tick) begin
      fast_above_q <= fast_now;
      trig_q       <= trig_now;
      if (fast_now) begin
        width_q <= width_q + {{(CW-1){1'b0}}, 1'b1};
      end else begin
        width_q <= {CW{1'b0}};
      end
    end
  end

  // per-event capture and rejection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reject_q  <= 1'b0;
      max_q     <= {DW{1'b0}};
      samp_q    <= {DW{1'b0}};
      adc_cap_q <= {AW{1'b0}};
    end else if (det) begin
      // a pulse inside a running interval rejects the old and the new event
      reject_q  <= pile_run;
      max_q     <= {DW{1'b0}};
      samp_q    <= {DW{1'b0}};
      adc_cap_q <= adc_sample;
    end else begin
      if (pile_run && dec_tick && fast_now && (width_q >= max_fast_pulse_width_q)) begin
        reject_q <= 1'b1;
      end
      if (in_win && (slow_filter > max_q)) begin
        max_q <= slow_filter;
      end
      if (samp_hit) begin
        samp_q <= slow_filter;
      end
    end
  end

  // accepted event: spectrum strobe and readable capture
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      spec_valid <= 1'b0;
      spec_step  <= {DW{1'b0}};
      spec_adc   <= {AW{1'b0}};
      ev_step_q  <= {DW{1'b0}};
      ev_adc_q   <= {AW{1'b0}};
    end else begin
      spec_valid <= ev_keep;
      if (ev_keep) begin
        spec_step <= step_val;
        spec_adc  <= adc_cap_q;
        ev_step_q <= step_val;
        ev_adc_q  <= adc_cap_q;
      end
    end
  end

  // ready and overrun flags; a new event wins over a software clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_ready_q   <= 1'b0;
      ev_overrun_q <= 1'b0;
    end else begin
      if (ev_keep) begin
        ev_ready_q <= 1'b1;
      end else if (wr_strb && (wr_addr_q == `PCPI_STATUS) && hwdata[`PCPI_ST_READY]) begin
        ev_ready_q <= 1'b0;
      end
      if (ev_keep && ev_ready_q) begin
        ev_overrun_q <= 1'b1;
      end else if (wr_strb && (wr_addr_q == `PCPI_STATUS) && hwdata[`PCPI_ST_OVERRUN]) begin
        ev_overrun_q <= 1'b0;
      end
    end
  end

  // baseline samples at the last tick of each quiet interval, while samples are valid
  wire base_hit = base_run && dec_tick && idle
                  && (base_count + {{(CW-1){1'b0}}, 1'b1} >= base_interval_q);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      base_step_q <= {DW{1'b0}};
      base_adc_q  <= {AW{1'b0}};
    end else if (base_hit) begin
      base_step_q <= slow_filter;
      base_adc_q  <= adc_sample;
    end
  end

  // run counters cleared on the rising run bit and frozen while stopped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_prev_q             <= 1'b0;
      realtime_q             <= 32'h00000000;
      livetime_q             <= 32'h00000000;
      detected_pulse_count_q <= 32'h00000000;
      captured_event_count_q <= 32'h00000000;
    end else begin
      run_prev_q <= run;
      if (run && !run_prev_q) begin
        realtime_q             <= 32'h00000000;
        livetime_q             <= 32'h00000000;
        detected_pulse_count_q <= 32'h00000000;
        captured_event_count_q <= 32'h00000000;
      end else if (run) begin
        realtime_q <= realtime_q + 32'h00000001;
        if (!fast_above_q) begin
          livetime_q <= livetime_q + 32'h00000001;
        end
        if (dec_tick && fast_now && !fast_above_q) begin
          detected_pulse_count_q <= detected_pulse_count_q + 32'h00000001;
        end
        if (ev_keep) begin
          captured_event_count_q <= captured_event_count_q + 32'h00000001;
        end
      end
    end
  end

  // bus handshake and pending write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= acc && hwrite && addr_ok;
      if (acc) begin
        wr_addr_q <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= addr_ok ? rd_mux : 32'h00000000;
      end
    end
  end

  // configuration writes in the data phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q                    <= `PCPI_CTRL_RESET;
      fast_thr_q                <= {DW{1'b0}};
      inter_thr_q               <= {DW{1'b0}};
      slow_filter_length_q      <= {CW{1'b0}};
      slow_filter_gap_q         <= {CW{1'b0}};
      peak_sample_delay_q       <= {CW{1'b0}};
      pileup_inspect_interval_q <= {CW{1'b0}};
      max_fast_pulse_width_q    <= {CW{1'b0}};
      base_interval_q           <= {CW{1'b0}};
    end else if (wr_strb) begin
      case (wr_addr_q)
        `PCPI_CTRL:      ctrl_q                    <= hwdata[4:0];
        `PCPI_FAST_THR:  fast_thr_q                <= hwdata[DW-1:0];
        `PCPI_INTER_THR: inter_thr_q               <= hwdata[DW-1:0];
        `PCPI_SLOW_LEN:  slow_filter_length_q      <= hwdata[CW-1:0];
        `PCPI_SLOW_GAP:  slow_filter_gap_q         <= hwdata[CW-1:0];
        `PCPI_SAMP_DLY:  peak_sample_delay_q       <= hwdata[CW-1:0];
        `PCPI_PILE_INT:  pileup_inspect_interval_q <= hwdata[CW-1:0];
        `PCPI_MAX_WIDTH: max_fast_pulse_width_q    <= hwdata[CW-1:0];
        `PCPI_BASE_INT:  base_interval_q           <= hwdata[CW-1:0];
        default:         ctrl_q                    <= ctrl_q;
      endcase
    end
  end

  // read data selection, unmapped offsets read zero
  always @* begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `PCPI_CTRL:      rd_mux[4:0]    = ctrl_q;
      `PCPI_FAST_THR:  rd_mux[DW-1:0] = fast_thr_q;
      `PCPI_INTER_THR: rd_mux[DW-1:0] = inter_thr_q;
      `PCPI_SLOW_LEN:  rd_mux[CW-1:0] = slow_filter_length_q;
      `PCPI_SLOW_GAP:  rd_mux[CW-1:0] = slow_filter_gap_q;
      `PCPI_SAMP_DLY:  rd_mux[CW-1:0] = peak_sample_delay_q;
      `PCPI_PILE_INT:  rd_mux[CW-1:0] = pileup_inspect_interval_q;
      `PCPI_MAX_WIDTH: rd_mux[CW-1:0] = max_fast_pulse_width_q;
      `PCPI_BASE_INT:  rd_mux[CW-1:0] = base_interval_q;
      `PCPI_STATUS: begin
        rd_mux[`PCPI_ST_READY]   = ev_ready_q;
        rd_mux[`PCPI_ST_OVERRUN] = ev_overrun_q;
        rd_mux[`PCPI_ST_BUSY]    = pile_run;
      end
      `PCPI_EV_STEP:   rd_mux[DW-1:0] = ev_step_q;
      `PCPI_EV_ADC:    rd_mux[AW-1:0] = ev_adc_q;
      `PCPI_BASE_STEP: rd_mux[DW-1:0] = base_step_q;
      `PCPI_BASE_ADC:  rd_mux[AW-1:0] = base_adc_q;
      `PCPI_REALTIME:  rd_mux         = realtime_q;
      `PCPI_LIVETIME:  rd_mux         = livetime_q;
      `PCPI_PULSES:    rd_mux         = detected_pulse_count_q;
      `PCPI_EVENTS:    rd_mux         = captured_event_count_q;
      default:         rd_mux         = 32'h00000000;
    endcase
  end

endmodule

// ==== pcpi_checker.sv ====
// port checker for the pulse capture and pileup inspector top
// assumes one clock domain with async active high reset
`timescale 1ns/1ps

module pcpi_checker #(
  parameter DW = 24,
  parameter AW = 12
) (
  // clock and reset
  input wire          clk,
  input wire          rst,
  // bus
  input wire          hsel,
  input wire [31:0]   haddr,
  input wire [1:0]    htrans,
  input wire          hwrite,
  input wire          hready,
  input wire [31:0]   hrdata,
  input wire          hreadyout,
  input wire          hresp,
  // events
  input wire          dec_tick,
  input wire          spec_valid,
  input wire [DW-1:0] spec_step,
  input wire [AW-1:0] spec_adc
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // read address phase taken at this edge
  wire rd = hsel && hready && htrans[1] && !hwrite;
  sequence far_read_s;
    rd && (haddr[31:8] != 24'h0);
  endsequence
  sequence tick_lead_s;
    $past(dec_tick, 2);
  endsequence

  ready_high_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  unmapped_read_a: assert property (far_read_s |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_held_a: assert property (!$past(rd) |-> $stable(hrdata))
    else $error("read data moved without read");
  valid_pulse_a: assert property (spec_valid |=> !spec_valid)
    else $error("event strobe longer than one cycle");
  step_held_a: assert property (!spec_valid |-> $stable(spec_step))
    else $error("step moved without event");
  adc_held_a: assert property (!spec_valid |-> $stable(spec_adc))
    else $error("amplitude moved without event");
  valid_tick_a: assert property (spec_valid |-> tick_lead_s)
    else $error("event not two clocks after a tick");
endmodule

bind pcpi_top pcpi_checker #(.DW(DW), .AW(AW)) pcpi_checker_inst (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .dec_tick(dec_tick), .spec_valid(spec_valid),
  .spec_step(spec_step), .spec_adc(spec_adc)
);

// ==== pcpi_filt_model.sv ====
// upstream filter model: one decimated tick every four clocks
// assumes the bench loads the next sample set right after a tick
`timescale 1ns/1ps

module pcpi_filt_model (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // next samples from the bench
  input  wire [23:0] f_in,
  input  wire [23:0] s_in,
  input  wire [11:0] a_in,
  // toward the inspector
  output wire        dec_tick,
  output wire [23:0] fast_filter,
  output wire [23:0] inter_filter,
  output wire [23:0] slow_filter,
  output wire [11:0] adc_sample
);
  reg [1:0]  cnt_q;
  reg        tick_q;
  reg [23:0] f_q;
  reg [23:0] s_q;
  reg [11:0] a_q;
  // capture a sample set and strobe the tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      tick_q <= 1'b0;
      f_q <= 24'h0;
      s_q <= 24'h0;
      a_q <= 12'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      tick_q <= (cnt_q == 2'h3);
      if (cnt_q == 2'h3) begin
        f_q <= f_in;
        s_q <= s_in;
        a_q <= a_in;
      end
    end
  end
  // between ticks samples are stale, so show their inverse
  assign dec_tick = tick_q;
  assign fast_filter = tick_q ? f_q : ~f_q;
  assign inter_filter = tick_q ? f_q : ~f_q;
  assign slow_filter = tick_q ? s_q : ~s_q;
  assign adc_sample = tick_q ? a_q : ~a_q;
endmodule

// ==== tb.sv ====
// self-checking bench for the pulse capture and pileup inspector
// assumes the filter model paces ticks and one zero-wait bus slave
`timescale 1ns/1ps
`include "pcpi_consts.vh"

module tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [23:0] f_in = 24'h0;
  reg  [23:0] s_in = 24'h22b;
  reg  [11:0] a_in = 12'h0aa;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        dec_tick;
  wire [23:0] fast_f;
  wire [23:0] inter_f;
  wire [23:0] slow_f;
  wire [11:0] adc_s;
  wire        spec_valid;
  wire [23:0] spec_step;
  wire [11:0] spec_adc;
  integer     miscompares = 0;
  integer     total_checks = 0;
  integer     nv = 0;
  reg  [23:0] gs = 24'h0;
  reg  [11:0] ga = 12'h0;
  reg  [31:0] rv;
  reg  [31:0] rt;

  always #2.5 clk = ~clk;

  pcpi_filt_model pcpi_filt_model_inst (
    .clk(clk), .rst(rst), .f_in(f_in), .s_in(s_in), .a_in(a_in),
    .dec_tick(dec_tick), .fast_filter(fast_f), .inter_filter(inter_f),
    .slow_filter(slow_f), .adc_sample(adc_s)
  );
  pcpi_top pcpi_top_inst (
    .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dec_tick(dec_tick), .fast_filter(fast_f), .inter_filter(inter_f),
    .slow_filter(slow_f), .adc_sample(adc_s), .spec_valid(spec_valid),
    .spec_step(spec_step), .spec_adc(spec_adc)
  );

  // record every accepted event
  always @(posedge clk) begin
    if (spec_valid === 1'b1) begin
      nv <= nv + 1;
      gs <= spec_step;
      ga <= spec_adc;
    end
  end

  task final_report;
    begin
      if (miscompares == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
    end
  endtask

  // one single word transfer, each phase held until hready
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rv = hrdata;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, {24'h0, a}, d);
  endtask

  task rc(input [7:0] a, input [31:0] e);
    begin
      xfer(1'b0, {24'h0, a}, 32'h0);
      chk(rv, e);
    end
  endtask

  // hand one sample set to the model and wait for its tick
  task tk(input [23:0] f, input [23:0] s, input [11:0] a);
    begin
      f_in <= f;
      s_in <= s;
      a_in <= a;
      @(posedge clk);
      while (dec_tick !== 1'b1) @(posedge clk);
    end
  endtask

  task idle(input integer n);
    repeat (n) tk(24'h0, 24'h22b, 12'h0aa);
  endtask

  // slow output per tick: early spike, peak inside the window
  function [23:0] sl(input integer k);
    sl = (k == 1) ? 24'h3e7 : (k == 4) ? 24'h5a : 24'ha * k[23:0];
  endfunction

  // pulse above threshold for w ticks, optional second rise at s2
  task ev(input integer w, input integer s2);
    integer k;
    begin
      idle(1);
      for (k = 0; k < 8; k = k + 1)
        tk((k < w || k == s2) ? 24'h80 : 24'h0, sl(k), 12'h100 + k[11:0]);
      idle(4);
    end
  endtask

  initial begin
    #50000;
    miscompares = miscompares + 1;
    final_report;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(`PCPI_CTRL, 32'h18);
    rc(`PCPI_STATUS, 32'h0);
    rc(`PCPI_EVENTS, 32'h0);
    xfer(1'b1, 32'h100, 32'h1);
    xfer(1'b0, 32'h100, 32'h0);
    chk(rv, 32'h0);
    rc(`PCPI_CTRL, 32'h18);
    wr(`PCPI_FAST_THR, 32'h64);
    wr(`PCPI_INTER_THR, 32'h64);
    wr(`PCPI_SLOW_LEN, 32'h4);
    wr(`PCPI_SLOW_GAP, 32'h2);
    wr(`PCPI_SAMP_DLY, 32'h5);
    wr(`PCPI_PILE_INT, 32'h6);
    wr(`PCPI_MAX_WIDTH, 32'h3);
    wr(`PCPI_BASE_INT, 32'h2);
    rc(`PCPI_PILE_INT, 32'h6);
    rc(`PCPI_SLOW_GAP, 32'h2);
    wr(`PCPI_CTRL, 32'h1b);
    ev(1, 9);
    chk(nv, 1);
    chk({8'h0, gs}, 32'h5a);
    chk({20'h0, ga}, 32'h100);
    rc(`PCPI_EV_STEP, 32'h5a);
    rc(`PCPI_EV_ADC, 32'h100);
    wr(`PCPI_CTRL, 32'h19);
    ev(1, 9);
    chk({8'h0, gs}, 32'h32);
    rc(`PCPI_STATUS, 32'h3);
    wr(`PCPI_STATUS, 32'h3);
    rc(`PCPI_STATUS, 32'h0);
    wr(`PCPI_CTRL, 32'h1b);
    ev(1, 3);
    chk(nv, 2);
    ev(5, 9);
    chk(nv, 2);
    wr(`PCPI_CTRL, 32'h0b);
    ev(1, 9);
    chk(nv, 3);
    rc(`PCPI_PULSES, 32'h5);
    rc(`PCPI_EVENTS, 32'h3);
    idle(8);
    rc(`PCPI_BASE_STEP, 32'h22b);
    rc(`PCPI_BASE_ADC, 32'haa);
    wr(`PCPI_CTRL, 32'h1a);
    xfer(1'b0, {24'h0, `PCPI_REALTIME}, 32'h0);
    rt = rv;
    rc(`PCPI_REALTIME, rt);
    xfer(1'b0, {24'h0, `PCPI_LIVETIME}, 32'h0);
    chk({31'h0, rv < rt}, 32'h1);
    wr(`PCPI_CTRL, 32'h1b);
    rc(`PCPI_EVENTS, 32'h0);
    final_report;
  end
endmodule
